/* File: verilog/rimlm_pkg.sv */
package rimlm_pkg;

	// Register offsets
	localparam logic [7:0] CONV_MASK_ADDR = 8'h22;
	localparam logic [7:0] LIN_MASK_ADDR = 8'h23;
	localparam logic [7:0] METER_SEL_ADDR = 8'h24;
	localparam logic [7:0] METER_HI_ADDR = 8'h25;
	localparam logic [7:0] METER_LO_ADDR = 8'h26;

	// Mask field positions, shared by both mask registers
	localparam int PG1_FALL_BIT = 7;
	localparam int PG1_RISE_BIT = 6;
	localparam int OC1_BIT = 4;
	localparam int PG0_FALL_BIT = 3;
	localparam int PG0_RISE_BIT = 2;
	localparam int OC0_BIT = 0;
	localparam logic [7:0] MASK_IMPL = 8'hdd;
	localparam int SEL_BIT = 0;

	// Reset values
	localparam logic [7:0] CONV_MASK_RST = 8'h4c | 8'h80;
	localparam logic [7:0] LIN_MASK_RST = 8'h0c;
	localparam logic [7:0] METER_SEL_RST = 8'h00;

	// Measurement scale and timing
	localparam int MA_PER_COUNT = 20;
	localparam int RESULT_W = 9;
	localparam int MEAS_TIME_US = 100;
	localparam int CLK_MHZ = 50;
	localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;

	// Raw condition set of one regulator
	typedef struct packed {
		logic pg_invalid;
		logic overcurrent;
	} rimlm_cond_s;

	// Interrupt flag set of one regulator
	typedef struct packed {
		logic pg_flag;
		logic overcurrent_flag;
	} rimlm_flag_s;

	// Meter state machine
	typedef enum logic [1:0] {
		METER_IDLE = 2'b01,
		METER_BUSY = 2'b10
	} rimlm_meter_e;

endpackage

/* File: verilog/rimlm_reg_events.sv */
`timescale 1ns/1ns
`default_nettype none

// Edge and flag logic of one regulator
module rimlm_reg_events
	import rimlm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Live condition
	input var rimlm_cond_s cond,
	// Masks
	input wire logic pg_fall_mask,
	input wire logic pg_rise_mask,
	input wire logic overcurrent_mask,
	// Flag clear from software
	input var rimlm_flag_s flag_clr,
	// Outputs
	output var rimlm_cond_s raw,
	output var rimlm_flag_s flags
);

	typedef struct packed {
		rimlm_cond_s prev;
		rimlm_flag_s flags;
	} rimlm_ev_state_s;

	rimlm_ev_state_s state_q;
	rimlm_ev_state_s state_d;
	logic pg_fall;
	logic pg_rise;
	logic oc_rise;

	// Edges of the live conditions against their registered copy
	assign pg_fall = cond.pg_invalid & ~state_q.prev.pg_invalid;
	assign pg_rise = ~cond.pg_invalid & state_q.prev.pg_invalid;
	assign oc_rise = cond.overcurrent & ~state_q.prev.overcurrent;

	// Set wins over clear
	always_comb begin
		state_d = state_q;
		state_d.prev = cond;
		state_d.flags.pg_flag = (state_q.flags.pg_flag & ~flag_clr.pg_flag)
			| (pg_fall & ~pg_fall_mask) | (pg_rise & ~pg_rise_mask);
		state_d.flags.overcurrent_flag = (state_q.flags.overcurrent_flag
			& ~flag_clr.overcurrent_flag) | (oc_rise & ~overcurrent_mask);
	end

	// State register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign raw = state_q.prev; // Raw status ignores masks
	assign flags = state_q.flags;

endmodule // rimlm_reg_events

`default_nettype wire

/* File: verilog/rimlm_top.sv */
// How it works
// - Conv mask bit7 default 1: conv1 fall
// - Conv mask bit6 default 1: conv1 rise
// - Conv mask bit4 default 0: conv1 overcurrent
// - Conv mask bit3 default 1: conv0 fall
// - Conv mask bit2 default 1: conv0 rise
// - Conv mask bit0 default 0: conv0 overcurrent
// - Masks gate flags only, raw follows live
// - Lin mask bit7 default 0: lin1 fall
// - Lin mask bit6 default 0: lin1 rise
// - Lin mask bit4: lin1 overcurrent
// - Lin mask bit3 default 1: lin0 fall
// - Lin mask bit2 default 1: lin0 rise
// - Lin mask bit0: lin0 overcurrent
// - Select bit0 at 0x24 picks converter
// - Any select write starts a measurement
// - 9-bit result: MSB 0x25 bit0, LSBs 0x26
// - 20 mA per count, 10.22 A full
// - Low result register read-only eight LSBs
// - Measurement done raises ready flag unless masked
// - Raw power-good 1 means invalid
`timescale 1ns/1ns
`default_nettype none

module rimlm_top
	import rimlm_pkg::*;
#(
	parameter int MEAS_CYC = MEAS_CYCLES
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Live regulator conditions
	input var rimlm_cond_s conv0_cond,
	input var rimlm_cond_s conv1_cond,
	input var rimlm_cond_s lin0_cond,
	input var rimlm_cond_s lin1_cond,
	// Analog load meter
	input wire logic [RESULT_W-1:0] conv0_load,
	input wire logic [RESULT_W-1:0] conv1_load,
	// Top-level meter ready mask
	input wire logic meter_ready_mask,
	// Flag clears, one per flag
	input var rimlm_flag_s conv0_clr,
	input var rimlm_flag_s conv1_clr,
	input var rimlm_flag_s lin0_clr,
	input var rimlm_flag_s lin1_clr,
	input wire logic meter_ready_clr,
	// Raw status
	output var rimlm_cond_s conv0_raw,
	output var rimlm_cond_s conv1_raw,
	output var rimlm_cond_s lin0_raw,
	output var rimlm_cond_s lin1_raw,
	// Interrupt flags
	output var rimlm_flag_s conv0_flags,
	output var rimlm_flag_s conv1_flags,
	output var rimlm_flag_s linear_irq_flags_0,
	output var rimlm_flag_s linear_irq_flags_1,
	output logic meter_ready_flag,
	output logic meter_busy
);

	typedef struct packed {
		logic [7:0] conv_mask;
		logic [7:0] lin_mask;
		logic [7:0] meter_sel;
		logic [RESULT_W-1:0] result;
		logic meas_conv;
		logic [31:0] meas_cnt;
		rimlm_meter_e meter_st;
		logic ready_flag;
		logic [7:0] rdata;
	} rimlm_state_s;

	rimlm_state_s state_q;
	rimlm_state_s state_d;
	logic [7:0] cm;
	logic [7:0] lm;
	logic meas_done;
	logic conv1_pg_fall_mask;
	logic conv1_pg_rise_mask;
	logic conv1_overcurrent_mask;
	logic conv0_pg_fall_mask;
	logic conv0_pg_rise_mask;
	logic conv0_overcurrent_mask;
	logic lin1_pg_fall_mask;
	logic lin1_pg_rise_mask;
	logic lin1_overcurrent_mask;
	logic lin0_pg_fall_mask;
	logic lin0_pg_rise_mask;
	logic lin0_overcurrent_mask;

	assign cm = state_q.conv_mask;
	assign lm = state_q.lin_mask;

	// Named converter mask fields
	assign conv1_pg_fall_mask = cm[PG1_FALL_BIT];
	assign conv1_pg_rise_mask = cm[PG1_RISE_BIT];
	assign conv1_overcurrent_mask = cm[OC1_BIT];
	assign conv0_pg_fall_mask = cm[PG0_FALL_BIT];
	assign conv0_pg_rise_mask = cm[PG0_RISE_BIT];
	assign conv0_overcurrent_mask = cm[OC0_BIT];

	// Named linear regulator mask fields
	assign lin1_pg_fall_mask = lm[PG1_FALL_BIT];
	assign lin1_pg_rise_mask = lm[PG1_RISE_BIT];
	assign lin1_overcurrent_mask = lm[OC1_BIT];
	assign lin0_pg_fall_mask = lm[PG0_FALL_BIT];
	assign lin0_pg_rise_mask = lm[PG0_RISE_BIT];
	assign lin0_overcurrent_mask = lm[OC0_BIT];

	// Converter 0 events
	rimlm_reg_events u_conv0 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.cond(conv0_cond),
		.pg_fall_mask(conv0_pg_fall_mask),
		.pg_rise_mask(conv0_pg_rise_mask),
		.overcurrent_mask(conv0_overcurrent_mask),
		.flag_clr(conv0_clr),
		.raw(conv0_raw),
		.flags(conv0_flags)
	);

	// Converter 1 events
	rimlm_reg_events u_conv1 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.cond(conv1_cond),
		.pg_fall_mask(conv1_pg_fall_mask),
		.pg_rise_mask(conv1_pg_rise_mask),
		.overcurrent_mask(conv1_overcurrent_mask),
		.flag_clr(conv1_clr),
		.raw(conv1_raw),
		.flags(conv1_flags)
	);

	// Linear regulator 0 events
	rimlm_reg_events u_lin0 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.cond(lin0_cond),
		.pg_fall_mask(lin0_pg_fall_mask),
		.pg_rise_mask(lin0_pg_rise_mask),
		.overcurrent_mask(lin0_overcurrent_mask),
		.flag_clr(lin0_clr),
		.raw(lin0_raw),
		.flags(linear_irq_flags_0)
	);

	// Linear regulator 1 events
	rimlm_reg_events u_lin1 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.cond(lin1_cond),
		.pg_fall_mask(lin1_pg_fall_mask),
		.pg_rise_mask(lin1_pg_rise_mask),
		.overcurrent_mask(lin1_overcurrent_mask),
		.flag_clr(lin1_clr),
		.raw(lin1_raw),
		.flags(linear_irq_flags_1)
	);

	assign meas_done = (state_q.meter_st == METER_BUSY)
		&& (state_q.meas_cnt == 32'(MEAS_CYC - 1));

	// Register writes, meter sequence and read data
	always_comb begin
		state_d = state_q;
		// Writes
		if (reg_wr) begin
			case (reg_addr)
				CONV_MASK_ADDR: begin
					// Reserved bits 5 and 1 stay zero
					state_d.conv_mask = reg_wdata & MASK_IMPL;
				end
				LIN_MASK_ADDR: begin
					// Reserved bits 5 and 1 stay zero
					state_d.lin_mask = reg_wdata & MASK_IMPL;
				end
				METER_SEL_ADDR: begin
					// Reserved bits kept but unused
					state_d.meter_sel = reg_wdata;
				end
				default: ;
			endcase
		end
		// Meter sequence
		case (state_q.meter_st)
			METER_IDLE: begin
				state_d.meas_cnt = '0;
			end
			METER_BUSY: begin
				state_d.meas_cnt = state_q.meas_cnt + 32'd1;
				if (meas_done) begin
					state_d.meter_st = METER_IDLE;
					// Result in 20 mA counts
					state_d.result = state_q.meas_conv ? conv1_load : conv0_load;
				end
			end
			default: state_d.meter_st = METER_IDLE;
		endcase
		// Any select write restarts the meter
		if (reg_wr && reg_addr == METER_SEL_ADDR) begin
			state_d.meter_st = METER_BUSY;
			state_d.meas_cnt = '0;
			state_d.meas_conv = reg_wdata[SEL_BIT];
		end
		// Ready flag, set wins over clear
		state_d.ready_flag = (state_q.ready_flag & ~meter_ready_clr)
			| (meas_done & ~meter_ready_mask);
		// Read data
		state_d.rdata = state_q.rdata;
		if (reg_rd) begin
			case (reg_addr)
				CONV_MASK_ADDR: state_d.rdata = state_q.conv_mask;
				LIN_MASK_ADDR: state_d.rdata = state_q.lin_mask;
				METER_SEL_ADDR: state_d.rdata = state_q.meter_sel;
				METER_HI_ADDR: begin
					// Only the result MSB, upper bits zero
					state_d.rdata = {7'h00, state_q.result[8]};
				end
				METER_LO_ADDR: begin
					// Eight result LSBs
					state_d.rdata = state_q.result[7:0];
				end
				default: state_d.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q.conv_mask <= CONV_MASK_RST;
			state_q.lin_mask <= LIN_MASK_RST;
			state_q.meter_sel <= METER_SEL_RST;
			state_q.result <= '0;
			state_q.meas_conv <= 1'b0;
			state_q.meas_cnt <= '0;
			state_q.meter_st <= METER_IDLE;
			state_q.ready_flag <= 1'b0;
			state_q.rdata <= 8'h00;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs
	assign reg_rdata = state_q.rdata;
	assign meter_ready_flag = state_q.ready_flag;
	assign meter_busy = (state_q.meter_st == METER_BUSY);

endmodule // rimlm_top

`default_nettype wire

/* File: tb/rimlm_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module rimlm_top_asserts
	import rimlm_pkg::*;
#(parameter int MEAS_CYC = 8)
(
	// Watched ports
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input var rimlm_cond_s conv0_cond,
	input var rimlm_cond_s conv0_raw,
	input var rimlm_flag_s conv0_flags,
	input var rimlm_flag_s conv0_clr,
	input wire logic meter_ready_mask,
	input wire logic meter_ready_flag,
	input wire logic meter_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic sel_wr;
	logic [15:0] cnt_q, cnt_d;
	// Cycles since the last select write
	assign sel_wr = reg_wr && reg_addr == METER_SEL_ADDR;
	assign cnt_d = sel_wr ? 16'h0 : cnt_q + 16'h1;
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn) cnt_q <= 16'h0;
		else cnt_q <= cnt_d;
	property p_raw; $past(rstn) |-> conv0_raw == $past(conv0_cond); endproperty
	a_raw: assert property (p_raw) else $error("raw lag");
	property p_pg; $rose(conv0_flags.pg_flag) |->
		$past(conv0_cond.pg_invalid) != $past(conv0_cond.pg_invalid, 2); endproperty
	a_pg: assert property (p_pg) else $error("pg flag cause");
	property p_oc; $rose(conv0_flags.overcurrent_flag) |->
		$past(conv0_cond.overcurrent) && !$past(conv0_cond.overcurrent, 2); endproperty
	a_oc: assert property (p_oc) else $error("oc flag cause");
	property p_hold; conv0_flags.pg_flag && !conv0_clr.pg_flag |=> conv0_flags.pg_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_start; sel_wr |=> meter_busy; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_len; meter_busy |-> cnt_q <= MEAS_CYC + 1; endproperty
	a_len: assert property (p_len) else $error("busy long");
	property p_rdy; $rose(meter_ready_flag) |-> $past(meter_busy) && !$past(meter_ready_mask);
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready cause");
	property p_unm; reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	// Main scenarios
	c_pg: cover property ($rose(conv0_flags.pg_flag));
	c_rdy: cover property ($rose(meter_ready_flag));
	c_end: cover property ($fell(meter_busy));
endmodule // rimlm_top_asserts
bind rimlm_top rimlm_top_asserts #(.MEAS_CYC(MEAS_CYC)) u_chk (.ref_clk, .rstn, .reg_wr,
	.reg_rd, .reg_addr, .reg_rdata, .conv0_cond, .conv0_raw, .conv0_flags, .conv0_clr,
	.meter_ready_mask, .meter_ready_flag, .meter_busy);
`default_nettype wire

/* File: tb/rimlm_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module rimlm_top_tb;
	import rimlm_pkg::*;
	logic ref_clk, rstn, reg_wr, reg_rd, meter_ready_mask, meter_ready_clr;
	logic meter_ready_flag, meter_busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [8:0] conv0_load, conv1_load;
	rimlm_cond_s [3:0] cnd, raw;
	rimlm_flag_s [3:0] clr, flg;
	int n_fail, num_checks;
	// Address, written, read back
	logic [23:0] rows [7] = '{24'h22ffdd, 24'h23ffdd, 24'h220000, 24'h24fefe,
		24'h25ff00, 24'h26ff00, 24'h30ff00};
	logic [7:0] mv [4] = '{8'h00, 8'h88, 8'h44, 8'h11};
	rimlm_top #(.MEAS_CYC(8)) dut (.ref_clk, .rstn, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .conv0_cond(cnd[0]), .conv1_cond(cnd[1]),
		.lin0_cond(cnd[2]), .lin1_cond(cnd[3]), .conv0_load, .conv1_load,
		.meter_ready_mask, .conv0_clr(clr[0]), .conv1_clr(clr[1]), .lin0_clr(clr[2]),
		.lin1_clr(clr[3]), .meter_ready_clr, .conv0_raw(raw[0]), .conv1_raw(raw[1]),
		.lin0_raw(raw[2]), .lin1_raw(raw[3]), .conv0_flags(flg[0]), .conv1_flags(flg[1]),
		.linear_irq_flags_0(flg[2]), .linear_irq_flags_1(flg[3]), .meter_ready_flag,
		.meter_busy);
	// Clock
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	task step(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task chk(string s, logic [8:0] e, logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h got %h", s, e, g);
		end
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		step(1);
		reg_wr = 0;
	endtask
	task rd(logic [7:0] a, logic [7:0] e);
		reg_addr = a;
		reg_rd = 1;
		step(1);
		reg_rd = 0;
		step(1);
		chk("rdata", {1'b0, e}, {1'b0, reg_rdata});
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wait_idle;
		for (int i = 0; i < 50 && meter_busy !== 1'b0; i++)
			step(1);
		if (meter_busy !== 1'b0) begin
			n_fail++;
			finish_test;
		end
		step(1);
	endtask
	// One regulator: fault and recovery under mask m
	task ev(int k, logic [7:0] a, logic [7:0] m);
		int h;
		h = (k % 2) * 4;
		wr(a, m);
		cnd[k] = 2'b11;
		step(2);
		chk("raw", 9'h3, {7'h0, raw[k]});
		chk("flags", {7'h0, ~m[h+3], ~m[h]}, {7'h0, flg[k]});
		clr[k] = 2'b11;
		step(1);
		clr[k] = 2'b00;
		cnd[k] = 2'b00;
		step(2);
		chk("raw", 9'h0, {7'h0, raw[k]});
		chk("flags", {7'h0, ~m[h+2], 1'b0}, {7'h0, flg[k]});
		clr[k] = 2'b11;
		step(1);
		clr[k] = 2'b00;
	endtask
	initial begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata, cnd, clr} = '0;
		{meter_ready_mask, meter_ready_clr, n_fail, num_checks} = '0;
		conv0_load = 9'h0a5;
		conv1_load = 9'h1ff;
		step(8);
		rstn = 1;
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		$display("register table done");
		// Reset in mid-run, then defaults
		rstn = 0;
		step(2);
		rstn = 1;
		rd(CONV_MASK_ADDR, 8'hcc);
		rd(LIN_MASK_ADDR, 8'h0c);
		rd(METER_SEL_ADDR, 8'h00);
		$display("reset defaults done");
		foreach (mv[j])
			for (int k = 0; k < 4; k++)
				ev(k, k < 2 ? CONV_MASK_ADDR : LIN_MASK_ADDR, mv[j]);
		$display("mask sweep done");
		// Converter 1 at full scale, then masked converter 0
		wr(METER_SEL_ADDR, 8'h01);
		chk("busy", 9'h1, {8'h0, meter_busy});
		wait_idle;
		chk("ready", 9'h1, {8'h0, meter_ready_flag});
		rd(METER_HI_ADDR, 8'h01);
		rd(METER_LO_ADDR, 8'hff);
		meter_ready_clr = 1;
		meter_ready_mask = 1;
		step(1);
		meter_ready_clr = 0;
		wr(METER_SEL_ADDR, 8'h00);
		wait_idle;
		chk("ready", 9'h0, {8'h0, meter_ready_flag});
		rd(METER_HI_ADDR, 8'h00);
		rd(METER_LO_ADDR, 8'ha5);
		$display("meter done");
		finish_test;
	end
endmodule // rimlm_top_tb
`default_nettype wire
